// File: hw/bom_cfg.svh
/*
 Register offsets, field positions, write masks and reset values of the
 breakout output mode block. Assumes byte addressing on a 12-bit bus address.
*/
`ifndef BOM_CFG_SVH
`define BOM_CFG_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BOM_OFS_SINGLE_ENDED  12'h000
`define BOM_OFS_DIFFERENTIAL  12'h004
`define BOM_OFS_OPTO_COLLECTOR 12'h008

// ----------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------
`define BOM_FIELD_W        2
`define BOM_DIFF_LSB       0
`define BOM_OPTO_LSB       0
`define BOM_OC_LSB         16
`define BOM_SE11_LSB       22
`define BOM_OC_SEL_BASE    8

// ----------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------
`define BOM_MASK_SE        32'h00C0_0000
`define BOM_MASK_FULL      32'h00FF_FFFF
`define BOM_RST_WORD       32'h0000_0000

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define BOM_RESP_OKAY      2'h0
`define BOM_RESP_SLVERR    2'h2

`endif

// File: hw/bom_line_drv.sv
/*
 Line driver: turns each two-bit mode field into a registered line level.
 Assumes the dynamic sources come from logic on the same clock.
*/
`include "bom_cfg.svh"

module bom_line_drv (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// mode words in, lines out
	bom_lines_if.drv  lines
);

	bom_pkg::bom_line_state_t st_ff;
	bom_pkg::bom_line_state_t nxt_st;

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	function automatic logic [1:0] field_at(input logic [31:0] w, input int unsigned lsb);
		field_at = w[lsb +: `BOM_FIELD_W];
	endfunction

	function automatic logic line_level(input logic [1:0] m, input logic dyn);
		unique case (bom_pkg::bom_mode_t'(m))
			bom_pkg::BOM_MODE_LOW:  line_level = 1'b0;
			bom_pkg::BOM_MODE_HIGH: line_level = 1'b1;
			bom_pkg::BOM_MODE_DYN:  line_level = dyn;
			// reserved code falls back to a safe low
			bom_pkg::BOM_MODE_RSVD: line_level = 1'b0;
		endcase
	endfunction

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		// each line decodes its own field against its own-index source, open-collector lines against index plus 8
		for (int i = 0; i < 12; i++) begin
			nxt_st.diff[i] = line_level(field_at(lines.diff_mode_word, `BOM_DIFF_LSB + 2 * i),
				lines.dyn_src[i]);
		end
		for (int i = 0; i < 8; i++) begin
			nxt_st.opto[i] = line_level(field_at(lines.opto_oc_mode_word, `BOM_OPTO_LSB + 2 * i),
				lines.dyn_src[i]);
		end
		for (int i = 0; i < 4; i++) begin
			nxt_st.oc[i] = line_level(field_at(lines.opto_oc_mode_word, `BOM_OC_LSB + 2 * i),
				lines.dyn_src[i + `BOM_OC_SEL_BASE]);
		end
		nxt_st.se11 = line_level(field_at(lines.se_mode_word, `BOM_SE11_LSB), lines.dyn_src[11]);
		if (!aresetn) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	assign lines.diff_line = st_ff.diff;
	assign lines.opto_line = st_ff.opto;
	assign lines.oc_line   = st_ff.oc;
	assign lines.se11_line = st_ff.se11;

endmodule

// File: hw/bom_lines_if.sv
/*
 Carrier between the register file and the line driver: mode words,
 selected dynamic signals and the registered line levels.
 Assumes both ends run on the same clock.
*/
interface bom_lines_if;
	logic [31:0] se_mode_word;
	logic [31:0] diff_mode_word;
	logic [31:0] opto_oc_mode_word;
	logic [11:0] dyn_src;
	logic [11:0] diff_line;
	logic [7:0]  opto_line;
	logic [3:0]  oc_line;
	logic        se11_line;

	modport regs (
		output se_mode_word,
		output diff_mode_word,
		output opto_oc_mode_word,
		output dyn_src,
		input  diff_line,
		input  opto_line,
		input  oc_line,
		input  se11_line
	);

	modport drv (
		input  se_mode_word,
		input  diff_mode_word,
		input  opto_oc_mode_word,
		input  dyn_src,
		output diff_line,
		output opto_line,
		output oc_line,
		output se11_line
	);
endinterface

// File: hw/bom_pkg.sv
/*
 Types of the breakout output mode block: mode code and state records.
 Assumes bom_cfg.svh is compiled alongside for the numeric constants.
*/
package bom_pkg;

	// ----------------------------------------------------------------------
	// per-line mode code
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {
		BOM_MODE_LOW  = 2'h0,
		BOM_MODE_HIGH = 2'h1,
		BOM_MODE_DYN  = 2'h2,
		BOM_MODE_RSVD = 2'h3
	} bom_mode_t;

	// ----------------------------------------------------------------------
	// state of the bus slave and register file
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_got;
		logic        w_got;
		logic [11:0] waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] se_word;
		logic [31:0] diff_word;
		logic [31:0] oc_word;
	} bom_slave_state_t;

	// ----------------------------------------------------------------------
	// state of the line drivers
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [11:0] diff;
		logic [7:0]  opto;
		logic [3:0]  oc;
		logic        se11;
	} bom_line_state_t;

endpackage

// File: hw/bom_top.sv
/*
 Breakout output mode select: AXI4-Lite register file holding the per-line
 mode fields, driving registered output lines through the line driver.
 Assumes dynamic sources already selected by index, on the same clock,
 and a master with at most one write and one read under way. Unmapped
 word offsets answer with an error response; their writes are dropped
 and their reads return zero.
*/
// Notes on behaviour
// - Mode 00 drives the line low, mode 01 drives it high.
// - Mode 10 follows the dynamic source; code 11 is reserved for software.
// - Every line has its own field, set independently of the others.
// - Dynamic mode takes the selector whose index equals the line index, except on open-collector lines.
// - Differential mode word: line n in bits 2n+1..2n, bits 0 to 23.
// - Third word: optocoupler lines in bits 0-15, open-collector lines in 16-23.
// - Single-ended line 11 field at bits 23..22, same codes, selector 11.
// - Every mode field reads back the last value written.
// - Open-collector line n follows selector n plus 8.
// - Lines sharing a selector share its signal but keep own static levels.
`include "bom_cfg.svh"

module bom_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// axi4-lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// dynamic sources, one per selector index
	input  wire logic [11:0] dynamic_source,
	// output lines
	output logic [11:0]      differential_output_line,
	output logic [7:0]       optocoupler_output_line,
	output logic [3:0]       open_collector_output_line,
	output logic             single_ended_output_line11
);

	// ----------------------------------------------------------------------
	// state and carrier
	// ----------------------------------------------------------------------
	bom_pkg::bom_slave_state_t st_ff;
	bom_pkg::bom_slave_state_t nxt_st;

	bom_lines_if lines ();

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	function automatic logic [11:0] word_addr(input logic [11:0] a);
		word_addr = {a[11:2], 2'h0};
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		unique case (word_addr(a))
			`BOM_OFS_SINGLE_ENDED:   is_mapped = 1'b1;
			`BOM_OFS_DIFFERENTIAL:   is_mapped = 1'b1;
			`BOM_OFS_OPTO_COLLECTOR: is_mapped = 1'b1;
			default:                 is_mapped = 1'b0;
		endcase
	endfunction

	// byte enables widened to bit enables
	function automatic logic [31:0] strobe_lanes(input logic [3:0] strb);
		strobe_lanes = '0;
		for (int b = 0; b < 4; b++) begin
			strobe_lanes[8 * b +: 8] = {8{strb[b]}};
		end
	endfunction

	// byte-lane merge limited to the implemented bits
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] lane;
		lane  = strobe_lanes(strb) & mask;
		merge = ((old & ~lane) | (d & lane)) & mask;
	endfunction

	// bits that a write may change in the register at this address
	function automatic logic [31:0] write_mask(input logic [11:0] a);
		unique case (word_addr(a))
			`BOM_OFS_SINGLE_ENDED:   write_mask = `BOM_MASK_SE;
			`BOM_OFS_DIFFERENTIAL:   write_mask = `BOM_MASK_FULL;
			`BOM_OFS_OPTO_COLLECTOR: write_mask = `BOM_MASK_FULL;
			default:                 write_mask = '0;
		endcase
	endfunction

	// stored word behind a byte address, zero where nothing is mapped
	function automatic logic [31:0] read_word(input bom_pkg::bom_slave_state_t s, input logic [11:0] a);
		unique case (word_addr(a))
			`BOM_OFS_SINGLE_ENDED:   read_word = s.se_word;
			`BOM_OFS_DIFFERENTIAL:   read_word = s.diff_word;
			`BOM_OFS_OPTO_COLLECTOR: read_word = s.oc_word;
			default:                 read_word = '0;
		endcase
	endfunction

	// ----------------------------------------------------------------------
	// bus slave and register file
	// ----------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;

		// address and data are taken in either order and held
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end

		// both halves held: commit and answer in the same edge
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = is_mapped(st_ff.waddr) ? `BOM_RESP_OKAY : `BOM_RESP_SLVERR;
			unique case (word_addr(st_ff.waddr))
				`BOM_OFS_SINGLE_ENDED: begin
					nxt_st.se_word = merge(st_ff.se_word, st_ff.wdata, st_ff.wstrb,
						write_mask(st_ff.waddr));
				end
				`BOM_OFS_DIFFERENTIAL: begin
					nxt_st.diff_word = merge(st_ff.diff_word, st_ff.wdata, st_ff.wstrb,
						write_mask(st_ff.waddr));
				end
				`BOM_OFS_OPTO_COLLECTOR: begin
					nxt_st.oc_word = merge(st_ff.oc_word, st_ff.wdata, st_ff.wstrb,
						write_mask(st_ff.waddr));
				end
				default: begin
				end
			endcase
		end
		// the response stands until the master takes it
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// one write at a time: channels reopen only once idle, so no
		// second address can slip in while the first one commits
		nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
		nxt_st.wready  = !nxt_st.w_got && !nxt_st.bvalid;

		// reads answer on the same edge that takes the address
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = is_mapped(s_axi_araddr) ? `BOM_RESP_OKAY : `BOM_RESP_SLVERR;
			// a write that commits on this edge shows only in the next read
			nxt_st.rdata  = read_word(st_ff, s_axi_araddr);
		end
		// read data stand until the master takes them
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		nxt_st.arready = !nxt_st.rvalid;

		// reset overrides any handshake of the same edge
		if (!aresetn) begin
			nxt_st           = '0;
			nxt_st.se_word   = `BOM_RST_WORD;
			nxt_st.diff_word = `BOM_RST_WORD;
			nxt_st.oc_word   = `BOM_RST_WORD;
		end
	end

	always_ff @(posedge aclk) begin
		st_ff <= nxt_st;
	end

	// ----------------------------------------------------------------------
	// line driver
	// ----------------------------------------------------------------------
	assign lines.se_mode_word      = st_ff.se_word;
	assign lines.diff_mode_word    = st_ff.diff_word;
	assign lines.opto_oc_mode_word = st_ff.oc_word;
	assign lines.dyn_src           = dynamic_source;

	bom_line_drv u_drv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.lines   (lines)
	);

	// ----------------------------------------------------------------------
	// bus outputs
	// ----------------------------------------------------------------------
	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready  = st_ff.wready;
	assign s_axi_bvalid  = st_ff.bvalid;
	assign s_axi_bresp   = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid  = st_ff.rvalid;
	assign s_axi_rdata   = st_ff.rdata;
	assign s_axi_rresp   = st_ff.rresp;

	// ----------------------------------------------------------------------
	// output lines, registered in the line driver
	// ----------------------------------------------------------------------
	assign differential_output_line   = lines.diff_line;
	assign optocoupler_output_line    = lines.opto_line;
	assign open_collector_output_line = lines.oc_line;
	assign single_ended_output_line11 = lines.se11_line;

endmodule

// File: sim/bom_ext_equip.sv
/*
 Far side: equipment on the output drivers, registering what it sees.
 Assumes it shares the block's clock.
*/
module bom_ext_equip (
	// clock
	input wire logic        aclk,
	// driven lines, differential in the low bits
	input wire logic [24:0] lines_in,
	// captured levels
	output logic [24:0]     seen
);
	timeunit 1ns;
	timeprecision 100ps;
	// one edge of latency, so the bench samples mid-cycle
	always_ff @(posedge aclk) begin
		seen <= lines_in;
	end
endmodule

// File: sim/bom_top_properties.sv
/*
 Concurrent checks of bom_top, bound to its ports.
 Assumes a single clock domain with synchronous active-low reset.
*/
module bom_top_chk (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// bus handshakes
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// lines
	input wire logic [11:0] dynamic_source,
	input wire logic [11:0] differential_output_line,
	input wire logic [7:0]  optocoupler_output_line,
	input wire logic [3:0]  open_collector_output_line,
	input wire logic        single_ended_output_line11
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------------------------------------
	// bus handshakes
	// ----------------------------------------------------------------------
	hi_bits_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:24] == 8'h00)
		else $error("upper read bits set");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	// commit and answer take the one edge after both halves are held
	write_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	// ----------------------------------------------------------------------
	// a line may only move after a mode write or a source change
	// ----------------------------------------------------------------------
	diff_cause_a: assert property (
		$changed(differential_output_line) |->
		$past(s_axi_bvalid) || $past(dynamic_source) != $past(dynamic_source, 2))
		else $error("differential line moved alone");
	other_cause_a: assert property (
		$changed({optocoupler_output_line, open_collector_output_line, single_ended_output_line11}) |->
		$past(s_axi_bvalid) || $past(dynamic_source) != $past(dynamic_source, 2))
		else $error("line moved alone");
	reset_low_a: assert property (
		$rose(aresetn) |-> {differential_output_line, optocoupler_output_line,
		open_collector_output_line, single_ended_output_line11} == 25'h0)
		else $error("lines not low after reset");
	write_c: cover property (s_axi_bvalid && s_axi_bready);
	read_c: cover property (s_axi_rvalid && s_axi_rready);
	err_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
	wait_c: cover property (s_axi_rvalid && !s_axi_rready);
endmodule

bind bom_top bom_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
	.s_axi_rready, .dynamic_source, .differential_output_line, .optocoupler_output_line,
	.open_collector_output_line, .single_ended_output_line11);

// File: sim/tb_breakout_output_mode_select.sv
/*
 Bench of bom_top: bus master, reference model, far-side receiver.
 Assumes one 40 MHz clock and synchronous reset.
*/
`include "bom_cfg.svh"
module tb_breakout_output_mode_select;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk, aresetn = 1'b0;
	logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
	logic [11:0] awa = 12'h000, ara = 12'h000, dyn = 12'h000;
	logic [31:0] wd = 32'h0000_0000, ms, md, mo;
	logic [3:0]  ws = 4'h0;
	wire         awr, wrr, bv, arr, rv;
	wire [1:0]   br, rr;
	wire [31:0]  rdat;
	wire [24:0]  lv, seen;
	int          mismatches = 0, checks_done = 0, cyc = 0;

	bom_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy), .dynamic_source(dyn), .differential_output_line(lv[11:0]),
		.optocoupler_output_line(lv[19:12]), .open_collector_output_line(lv[23:20]),
		.single_ended_output_line11(lv[24]));
	bom_ext_equip far (.aclk(aclk), .lines_in(lv), .seen(seen));

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			$display("mismatch at %0t: timeout", $time);
			test_done();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	// reserved code falls to low
	function automatic logic lvl(input logic [1:0] c, input logic src);
		return c == 2'h1 || (c == 2'h2 && src);
	endfunction

	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic aw, w;
		logic [31:0] m;
		aw = 1'b1;
		w = 1'b1;
		awa <= a;
		wd <= d;
		ws <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && awr) begin
				aw = 1'b0;
				awv <= 1'b0;
			end
			if (w && wrr) begin
				w = 1'b0;
				wv <= 1'b0;
			end
		end
		// leave the response waiting now and then
		repeat ($urandom_range(2)) @(posedge aclk);
		brdy <= 1'b1;
		do @(posedge aclk); while (!bv);
		m = (a[11:2] == 10'h1) ? md : (a[11:2] == 10'h2) ? mo : ms;
		for (int b = 0; b < 4; b++) if (s[b]) m[8*b +: 8] = d[8*b +: 8];
		case (a[11:2])
			10'h0: ms = m & `BOM_MASK_SE;
			10'h1: md = m & `BOM_MASK_FULL;
			10'h2: mo = m & `BOM_MASK_FULL;
			default: m = 32'h0000_0000;
		endcase
		chk(br, (a[11:2] < 10'h3) ? 2'h0 : 2'h2);
		brdy <= 1'b0;
	endtask

	task automatic bus_rd(input logic [11:0] a);
		logic [31:0] e;
		e = (a[11:2] == 10'h0) ? ms : (a[11:2] == 10'h1) ? md : (a[11:2] == 10'h2) ? mo : 32'h0000_0000;
		ara <= a;
		arv <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		repeat ($urandom_range(2)) @(posedge aclk);
		rrdy <= 1'b1;
		do @(posedge aclk); while (!rv);
		chk(rdat, e);
		chk(rr, (a[11:2] < 10'h3) ? 2'h0 : 2'h2);
		rrdy <= 1'b0;
	endtask

	task automatic see_lines(input logic [11:0] v);
		logic [24:0] e;
		for (int i = 0; i < 12; i++) e[i] = lvl(md[2*i +: 2], v[i]);
		for (int i = 0; i < 8; i++) e[12+i] = lvl(mo[2*i +: 2], v[i]);
		for (int i = 0; i < 4; i++) e[20+i] = lvl(mo[16+2*i +: 2], v[8+i]);
		e[24] = lvl(ms[23:22], v[11]);
		dyn <= v;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
		chk(seen, e);
		@(posedge aclk);
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h18197E0E));
		ms = `BOM_RST_WORD;
		md = `BOM_RST_WORD;
		mo = `BOM_RST_WORD;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int r = 0; r < 16; r += 4) bus_rd(12'(r));
		see_lines(12'hFFF);
		$display("test reset values done");
		// every code on every field, upper bits set to probe the unused byte
		for (int k = 0; k < 4; k++) begin
			for (int r = 0; r < 12; r += 4) begin
				bus_wr(12'(r), {16{2'(k)}}, 4'hF);
				bus_rd(12'(r));
			end
			see_lines(12'($urandom));
			see_lines(12'($urandom));
		end
		$display("test mode codes done");
		for (int n = 0; n < 24; n++) begin
			bus_wr(12'($urandom_range(3) * 4), $urandom, 4'($urandom));
			bus_rd(12'($urandom_range(3) * 4));
			see_lines(12'($urandom));
		end
		$display("test random access done");
		test_done();
	end
endmodule
